// ===== pkg/ide_bridge_params.svh
// constants of the card bridge: control offsets, bit positions, cycle timing
// assumes a 100 MHz clock; counts derive from the times below
`ifndef IDE_BRIDGE_PARAMS_SVH
`define IDE_BRIDGE_PARAMS_SVH

`define CTL_OFS_CARD 2'h0
`define CTL_OFS_IFACE 2'h1
`define BIT_DET 0
`define BIT_CARD_POWER 1
`define BIT_RST 2
`define BIT_PRESENCE_IRQ_ENABLE 3
`define BIT_CARD_IRQ_ENABLE 0
`define RST_CARD_POWER 1'h0
`define RST_CARD_RESET 1'h1

`define CLK_PERIOD_NS 10
`define T_SETUP_NS 70
`define T_PULSE_NS 165
`define T_HOLD_NS 30
`define T_CYCLE_NS 600
`define T_RECOVER_NS (`T_CYCLE_NS - `T_SETUP_NS - `T_PULSE_NS - `T_HOLD_NS)
`define SETUP_CYC ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CYC ((`T_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC ((`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_CYC ((`T_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== pkg/ide_bridge_pkg.sv
// types shared by the card bridge modules
// assumes the params header supplies all numeric constants
package ide_bridge_pkg;
  typedef enum logic [2:0] {
    CYC_IDLE,
    CYC_SETUP,
    CYC_STROBE,
    CYC_HOLD,
    CYC_RECOVER
  } cycle_state_t;
  typedef logic [5:0] cyc_cnt_t;
endpackage

// ===== rtl/card_cycle_engine.sv
// one card register cycle: setup, strobe, ready stall, hold, recovery
// assumes ready and data inputs are already synchronised to clk_i
`include "ide_bridge_params.svh"
module card_cycle_engine
  import ide_bridge_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic write_i,
  input wire logic [3:0] ofs_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] data_s_i,
  input wire logic ready_s_i,
  output logic done_o,
  output logic [15:0] rdata_o,
  output logic [10:0] addr_o,
  output logic [1:0] cs_n_o,
  output logic iord_n_o,
  output logic iowr_n_o,
  output logic [15:0] data_o,
  output logic data_oe_o
);
  cycle_state_t state, next_state;
  cyc_cnt_t cnt, next_cnt;
  logic is_write, cs_sel;

  function automatic cyc_cnt_t load(input int n);
    return cyc_cnt_t'(n - 1);
  endfunction

  wire cnt_zero = (cnt == 6'h00);
  wire take = (state == CYC_IDLE) && req_i;
  wire wr_now = take ? write_i : is_write;
  wire sel_now = take ? ofs_i[3] : cs_sel;
  wire next_open = (next_state == CYC_SETUP) || (next_state == CYC_STROBE) ||
                   (next_state == CYC_HOLD);
  wire next_strobe = (next_state == CYC_STROBE);
  wire finish = (state == CYC_STROBE) && (next_state == CYC_HOLD);

  // pio mode 0 only: every phase has the slowest legal length
  always_comb begin
    next_state = state;
    next_cnt = cnt_zero ? cnt : cnt - 6'h01;
    case (state)
      CYC_IDLE: if (req_i) begin
        next_state = CYC_SETUP;
        next_cnt = load(`SETUP_CYC);
      end
      CYC_SETUP: if (cnt_zero) begin
        next_state = CYC_STROBE;
        next_cnt = load(`PULSE_CYC);
      end
      // a card holding ready low stretches the strobe
      CYC_STROBE: if (cnt_zero && ready_s_i) begin
        next_state = CYC_HOLD;
        next_cnt = load(`HOLD_CYC);
      end
      CYC_HOLD: if (cnt_zero) begin
        next_state = CYC_RECOVER;
        next_cnt = load(`RECOVER_CYC);
      end
      CYC_RECOVER: if (cnt_zero) begin
        next_state = CYC_IDLE;
      end
      default: next_state = CYC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= CYC_IDLE;
      cnt <= 6'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // offsets 0..7 go to the first select, 8..15 to the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      is_write <= 1'b0;
      cs_sel <= 1'b0;
      addr_o <= 11'h000;
      data_o <= 16'h0000;
    end else if (take) begin
      is_write <= write_i;
      cs_sel <= ofs_i[3];
      addr_o <= {8'h00, ofs_i[2:0]};
      data_o <= wdata_i;
    end
  end

  // pins follow the next state so they change with the state itself
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_n_o <= 2'h3;
      iord_n_o <= 1'b1;
      iowr_n_o <= 1'b1;
      data_oe_o <= 1'b0;
    end else begin
      cs_n_o <= next_open ? (sel_now ? 2'h1 : 2'h2) : 2'h3;
      iord_n_o <= !(next_strobe && !wr_now);
      iowr_n_o <= !(next_strobe && wr_now);
      data_oe_o <= next_open && wr_now;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
      rdata_o <= 16'h0000;
    end else begin
      done_o <= finish;
      if (finish && !is_write) begin
        rdata_o <= data_s_i;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  wire strobe_act = !iord_n_o || !iowr_n_o;

  sequence s_strobe_start;
    $rose(strobe_act);
  endsequence

  property p_setup_before_strobe;
    s_strobe_start |-> $past(cs_n_o != 2'h3, 7) && cs_n_o != 2'h3;
  endproperty
  a_setup_before_strobe: assert property (p_setup_before_strobe)
    else $error("strobe started without address setup");

  property p_pulse_width;
    s_strobe_start |-> ##16 strobe_act;
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("strobe shorter than pulse time");

  property p_ready_stall;
    strobe_act && !ready_s_i |=> strobe_act;
  endproperty
  a_ready_stall: assert property (p_ready_stall)
    else $error("strobe ended while card not ready");

  property p_done_after_strobe;
    done_o |-> !strobe_act && $past(strobe_act) ##1 cs_n_o != 2'h3;
  endproperty
  a_done_after_strobe: assert property (p_done_after_strobe)
    else $error("done without a finished strobe and hold");

  property p_write_drives_data;
    !iowr_n_o |-> data_oe_o && iord_n_o;
  endproperty
  a_write_drives_data: assert property (p_write_drives_data)
    else $error("write strobe without data drive");
endmodule

// ===== rtl/ide_card_bridge.sv
// bridge from a host register port to a card in true ide mode
// assumes host ports on clk_i; card pins asynchronous; host holds a card
// request until card_ack_o pulses
`include "ide_bridge_params.svh"
module ide_card_bridge
  import ide_bridge_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic card_read_i,
  input wire logic card_write_i,
  input wire logic [3:0] card_addr_i,
  input wire logic [15:0] card_wdata_i,
  output logic [15:0] card_rdata_o,
  output logic card_ack_o,
  input wire logic ctl_read_i,
  input wire logic ctl_write_i,
  input wire logic [1:0] ctl_addr_i,
  input wire logic [31:0] ctl_wdata_i,
  output logic [31:0] ctl_rdata_o,
  output logic irq_presence_o,
  output logic irq_card_o,
  output logic [10:0] addr_o,
  output logic [1:0] cs_n_o,
  output logic atasel_n_o,
  output logic iord_n_o,
  output logic iowr_n_o,
  output logic we_n_o,
  output logic rfu_o,
  output logic reset_n_o,
  output logic power_o,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic data_oe_o,
  input wire logic detect_i,
  input wire logic intrq_i,
  input wire logic iordy_i
);
  logic [18:0] pin_meta, pin_sync;
  logic det_prev;
  logic presence_irq_enable, card_irq_enable;

  // two stages for every card pin; data is only read late in the strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta <= 19'h00000;
      pin_sync <= 19'h00000;
    end else begin
      pin_meta <= {detect_i, intrq_i, iordy_i, data_i};
      pin_sync <= pin_meta;
    end
  end

  wire det_s = pin_sync[18];
  wire intrq_s = pin_sync[17];
  wire iordy_s = pin_sync[16];
  wire [15:0] data_s = pin_sync[15:0];

  // control port decode, kept apart from the card port
  wire sel_card = (ctl_addr_i == `CTL_OFS_CARD);
  wire sel_iface = (ctl_addr_i == `CTL_OFS_IFACE);
  wire wr_card = ctl_write_i && sel_card;
  wire wr_iface = ctl_write_i && sel_iface;
  wire rd_card = ctl_read_i && sel_card;

  wire [3:0] card_word = {presence_irq_enable, !reset_n_o, power_o, det_s};
  wire [3:0] iface_word = {3'h0, card_irq_enable};
  wire [3:0] rd_word = sel_card ? card_word : (sel_iface ? iface_word : 4'h0);

  wire det_change = (det_s != det_prev);
  // set wins over the read-clear so a change in that cycle is kept
  wire presence_set = det_change && presence_irq_enable;
  wire next_presence = presence_set || (irq_presence_o && !rd_card);

  // the card side always sits in true ide mode
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      atasel_n_o <= 1'b0;
      we_n_o <= 1'b1;
      rfu_o <= 1'b1;
    end else begin
      atasel_n_o <= 1'b0;
      we_n_o <= 1'b1;
      rfu_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_o <= `RST_CARD_POWER;
      reset_n_o <= !`RST_CARD_RESET;
      presence_irq_enable <= 1'b0;
    end else if (wr_card) begin
      power_o <= ctl_wdata_i[`BIT_CARD_POWER];
      reset_n_o <= !ctl_wdata_i[`BIT_RST];
      presence_irq_enable <= ctl_wdata_i[`BIT_PRESENCE_IRQ_ENABLE];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      card_irq_enable <= 1'b0;
    end else if (wr_iface) begin
      card_irq_enable <= ctl_wdata_i[`BIT_CARD_IRQ_ENABLE];
    end
  end

  // read data lands one cycle after the read strobe; reserved bits read zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_rdata_o <= 32'h00000000;
    end else begin
      ctl_rdata_o <= ctl_read_i ? {28'h0000000, rd_word} : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      det_prev <= 1'b0;
      irq_presence_o <= 1'b0;
      irq_card_o <= 1'b0;
    end else begin
      det_prev <= det_s;
      irq_presence_o <= next_presence;
      irq_card_o <= intrq_s && card_irq_enable;
    end
  end

  // one cycle engine; a held request is not restarted until recovery ends
  card_cycle_engine u_engine (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .req_i(card_read_i || card_write_i),
    .write_i(card_write_i),
    .ofs_i(card_addr_i),
    .wdata_i(card_wdata_i),
    .data_s_i(data_s),
    .ready_s_i(iordy_s),
    .done_o(card_ack_o),
    .rdata_o(card_rdata_o),
    .addr_o(addr_o),
    .cs_n_o(cs_n_o),
    .iord_n_o(iord_n_o),
    .iowr_n_o(iowr_n_o),
    .data_o(data_o),
    .data_oe_o(data_oe_o)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_card_write;
    ctl_write_i && ctl_addr_i == `CTL_OFS_CARD;
  endsequence

  property p_presence_set;
    det_s != det_prev && presence_irq_enable |=> irq_presence_o;
  endproperty
  a_presence_set: assert property (p_presence_set)
    else $error("detect change did not raise presence interrupt");

  property p_presence_clear;
    rd_card && !(det_s != det_prev && presence_irq_enable) |=> !irq_presence_o;
  endproperty
  a_presence_clear: assert property (p_presence_clear)
    else $error("control read did not clear presence interrupt");

  property p_presence_quiet;
    !irq_presence_o && (det_s == det_prev || !presence_irq_enable) |=> !irq_presence_o;
  endproperty
  a_presence_quiet: assert property (p_presence_quiet)
    else $error("presence interrupt without detect change");

  property p_card_irq_relay;
    intrq_s && card_irq_enable |=> irq_card_o;
  endproperty
  a_card_irq_relay: assert property (p_card_irq_relay)
    else $error("card interrupt not relayed");

  property p_card_irq_gate;
    !card_irq_enable |=> !irq_card_o;
  endproperty
  a_card_irq_gate: assert property (p_card_irq_gate)
    else $error("card interrupt forwarded while disabled");

  property p_power_reset_write;
    s_card_write |=> power_o == $past(ctl_wdata_i[`BIT_CARD_POWER]) &&
      reset_n_o == !$past(ctl_wdata_i[`BIT_RST]);
  endproperty
  a_power_reset_write: assert property (p_power_reset_write)
    else $error("power or reset pin does not follow control write");

  property p_detect_read;
    rd_card |=> ctl_rdata_o[`BIT_DET] == $past(det_s) &&
      ctl_rdata_o[31:4] == 28'h0000000;
  endproperty
  a_detect_read: assert property (p_detect_read)
    else $error("detect bit read back wrong");

  property p_ack_pulse;
    card_ack_o |=> !card_ack_o [*2];
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("card ack longer than one cycle");
endmodule

// ===== verification/ide_card_model.sv
// behavioural card in true ide mode: task-file store, ready stall, data bus
// assumes the bench resolves the shared data bus from the bridge enable
module ide_card_model (
  input wire logic clk_i,
  input wire logic [10:0] addr_i,
  input wire logic [1:0] cs_n_i,
  input wire logic iord_n_i,
  input wire logic iowr_n_i,
  input wire logic [15:0] bus_i,
  input wire logic [5:0] stall_i,
  output logic [15:0] bus_o,
  output logic iordy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [16];
  logic [15:0] last = 16'h5A5A;
  logic [5:0] wait_cnt = 6'h00;
  logic strobe_q = 1'b1;
  wire strobe = iord_n_i & iowr_n_i;
  wire sel = (cs_n_i != 2'b11);
  wire [3:0] idx = {cs_n_i[0], addr_i[2:0]};
  always @(posedge clk_i) begin
    strobe_q <= strobe;
    last <= bus_o;
    if (strobe_q && !strobe) begin
      wait_cnt <= stall_i;
    end else if (wait_cnt != 6'h00) begin
      wait_cnt <= wait_cnt - 6'h01;
    end
    if (sel && !iowr_n_i) begin
      mem[idx] <= bus_i;
    end
  end
  // read data is up from strobe start, well before ready returns
  assign iordy_o = (wait_cnt == 6'h00);
  // released bus shows a changing pattern, never the last word
  assign bus_o = (sel && !iord_n_i) ? mem[idx] : ~last;
endmodule

// ===== verification/ide_card_bridge_test.sv
// self-checking bench for the card bridge with a behavioural card
// assumes the bridge timing constants of the params header
`include "ide_bridge_params.svh"
module ide_card_bridge_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_n_i, card_read_i, card_write_i, ctl_read_i, ctl_write_i;
  logic [3:0] card_addr_i;
  logic [15:0] card_wdata_i, card_rdata_o, data_o, card_bus;
  logic [1:0] ctl_addr_i, cs_n_o;
  logic [31:0] ctl_wdata_i, ctl_rdata_o;
  logic card_ack_o, irq_presence_o, irq_card_o, atasel_n_o, iord_n_o, iowr_n_o;
  logic we_n_o, rfu_o, reset_n_o, power_o, data_oe_o, detect_i, intrq_i, iordy;
  logic [10:0] addr_o;
  logic [5:0] stall;
  int bad_count = 0;
  int samples_checked = 0;
  wire [15:0] bus = data_oe_o ? data_o : card_bus;
  ide_card_bridge uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .card_read_i(card_read_i),
    .card_write_i(card_write_i), .card_addr_i(card_addr_i), .card_wdata_i(card_wdata_i),
    .card_rdata_o(card_rdata_o), .card_ack_o(card_ack_o), .ctl_read_i(ctl_read_i),
    .ctl_write_i(ctl_write_i), .ctl_addr_i(ctl_addr_i), .ctl_wdata_i(ctl_wdata_i),
    .ctl_rdata_o(ctl_rdata_o), .irq_presence_o(irq_presence_o), .irq_card_o(irq_card_o),
    .addr_o(addr_o), .cs_n_o(cs_n_o), .atasel_n_o(atasel_n_o), .iord_n_o(iord_n_o),
    .iowr_n_o(iowr_n_o), .we_n_o(we_n_o), .rfu_o(rfu_o), .reset_n_o(reset_n_o),
    .power_o(power_o), .data_i(bus), .data_o(data_o), .data_oe_o(data_oe_o),
    .detect_i(detect_i), .intrq_i(intrq_i), .iordy_i(iordy));
  ide_card_model card (.clk_i(clk_i), .addr_i(addr_o), .cs_n_i(cs_n_o), .iord_n_i(iord_n_o),
    .iowr_n_i(iowr_n_o), .bus_i(bus), .stall_i(stall), .bus_o(card_bus), .iordy_o(iordy));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic ctl_wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    ctl_write_i <= 1'b1;
    ctl_addr_i <= a;
    ctl_wdata_i <= d;
    @(posedge clk_i);
    ctl_write_i <= 1'b0;
  endtask
  task automatic ctl_rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk_i);
    ctl_read_i <= 1'b1;
    ctl_addr_i <= a;
    @(posedge clk_i);
    ctl_read_i <= 1'b0;
    #1 d = ctl_rdata_o;
  endtask
  // counts setup and strobe cycles at the pins while the request is held
  task automatic card_xfer(input logic wr, input logic [3:0] a, input logic [15:0] wd,
                           output logic [15:0] rd, output int setup, output int pulse);
    int n;
    setup = 0;
    pulse = 0;
    @(posedge clk_i);
    card_read_i <= !wr;
    card_write_i <= wr;
    card_addr_i <= a;
    card_wdata_i <= wd;
    for (n = 0; n < 2000 && card_ack_o !== 1'b1; n++) begin
      @(posedge clk_i);
      if ((iord_n_o & iowr_n_o) !== 1'b1) begin
        pulse++;
        check("strobe kind", {31'h0, wr}, {31'h0, iord_n_o});
        check("data_oe_o", {31'h0, wr}, {31'h0, data_oe_o});
        check("addr_o", {21'h0, 8'h00, a[2:0]}, {21'h0, addr_o});
        check("cs_n_o", a[3] ? 32'h1 : 32'h2, {30'h0, cs_n_o});
      end else if (cs_n_o === 2'b11) begin
        // the previous access may still be in hold when this call starts
        setup = 0;
      end else if (pulse == 0) begin
        setup++;
      end
    end
    card_read_i <= 1'b0;
    card_write_i <= 1'b0;
    rd = card_rdata_o;
    if (n >= 2000) begin
      check("card_ack_o", 32'h1, 32'h0);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    // the tests need about 610 cycles
    ticks(5000);
    bad_count++;
    conclude();
  end
  logic [3:0] ofs [4] = '{4'h0, 4'h7, 4'h8, 4'hE};
  initial begin
    logic [31:0] d;
    logic [15:0] rd;
    int su, pu;
    {rst_n_i, card_read_i, card_write_i, ctl_read_i, ctl_write_i} = 5'b00000;
    {detect_i, intrq_i, card_addr_i, ctl_addr_i, stall} = 14'h0;
    card_wdata_i = 16'h0000;
    ctl_wdata_i = 32'h0;
    ticks(3);
    rst_n_i <= 1'b1;
    ticks(2);
    check("power_o", 32'h0, {31'h0, power_o});
    check("reset_n_o", 32'h0, {31'h0, reset_n_o});
    check("idle pins", 32'h1B, {27'h0, cs_n_o, atasel_n_o, we_n_o, rfu_o});
    ctl_rd(2'h0, d);
    check("card-control", 32'h4, d);
    ctl_wr(2'h0, 32'h2);
    ticks(2);
    check("power reset", 32'h3, {30'h0, power_o, reset_n_o});
    ctl_wr(2'h2, 32'hFFFFFFFF);
    ctl_rd(2'h2, d);
    check("unmapped", 32'h0, d);
    for (int i = 0; i < 8; i++) begin
      card_xfer(i < 4, ofs[i % 4], 16'hC3A0 + 16'(i % 4), rd, su, pu);
      check("setup", `SETUP_CYC, su);
      check("strobe", `PULSE_CYC, pu);
      if (i >= 4) check("card_rdata_o", 16'hC3A0 + 16'(i % 4), rd);
    end
    stall <= 6'd30;
    card_xfer(1'b0, 4'h8, 16'h0, rd, su, pu);
    check("stalled read", 32'hC3A2, {16'h0, rd});
    check("stall held", 32'h1, {31'h0, pu >= 30});
    stall <= 6'd0;
    ctl_wr(2'h0, 32'hA);
    check("no irq", 32'h0, {31'h0, irq_presence_o});
    for (int k = 0; k < 2; k++) begin
      detect_i <= !k;
      ticks(6);
      check("irq_presence_o", 32'h1, {31'h0, irq_presence_o});
      ctl_rd(2'h0, d);
      check("detect bit", {28'h0, 4'hA} | (k ? 32'h0 : 32'h1), d);
      ticks(1);
      check("irq cleared", 32'h0, {31'h0, irq_presence_o});
    end
    ctl_wr(2'h0, 32'h2);
    detect_i <= 1'b1;
    ticks(6);
    check("masked change", 32'h0, {31'h0, irq_presence_o});
    intrq_i <= 1'b1;
    ticks(6);
    check("card irq off", 32'h0, {31'h0, irq_card_o});
    ctl_wr(2'h1, 32'h1);
    ticks(4);
    check("irq_card_o", 32'h1, {31'h0, irq_card_o});
    ctl_rd(2'h1, d);
    check("iface-control", 32'h1, d);
    intrq_i <= 1'b0;
    ticks(6);
    check("card irq drop", 32'h0, {31'h0, irq_card_o});
    intrq_i <= 1'b1;
    ctl_wr(2'h1, 32'h0);
    ticks(4);
    check("card irq gated", 32'h0, {31'h0, irq_card_o});
    conclude();
  end
endmodule
